// ==== ssm_master.sv ====
// Serial master channel: clocked three-wire transmit or receive, with a
// single data buffer, interrupt pulse and a receive FIFO.
// Assumes all inputs are synchronous to REF_CLK; strobes last one cycle.
// Function
// R1: Transmit mode drives its own serial clock and shifts data out on SO.
// R2: Receive mode drives its own serial clock and captures SI data.
// R3: Frames are seven or eight bits in both directions.
// R4: Fastest clock is REF_CLK/2 on the fast channel, else REF_CLK/4.
// R5: Slowest clock REF_CLK/(2*2^15*128) through prescaler and divider.
// R6: Data phase 0 changes output at first edge; 1 presents half early.
// R7: Data phase likewise moves input sampling half a period earlier.
// R8: Polarity select 0 keeps serial clock plain, 1 inverts it.
// R9: Each frame goes most or least significant bit first.
// R10: Interrupt on transfer end (single) or buffer empty (continuous).
// R11: Transmit mode never raises any error flag.
// R12: Receive sets overflow when a frame arrives before the last was read; here only once the 16-entry receive FIFO is full.
// R13: A data write while the buffer is full replaces the pending word.
// R14: Software changes source select before the last transmit bit.
// R15: Software changes source select before the last receive bit.
// R16: After unit clock cut mid-stop, software waits then reinitialises.
// R17: With the unit clock off, writes are ignored and state reads default.
// R18: Stop trigger clears itself once the enable status reads zero.
// R19: Serial clock rests at its idle level whenever no frame shifts.
// R20: A received frame is stored and signalled at its last bit.
`timescale 1ns/10ps
`include "ssm_map.svh"
module ssm_master
  import ssm_pkg::*;
(
  input wire logic REF_CLK,
  input wire logic RESET,
  input wire logic UNIT_CLOCK_ENABLE,
  input wire logic CFG_WR,
  input wire logic CFG_RX_MODE,
  input wire logic CFG_SHORT_FRAME,
  input wire logic CFG_DATA_PHASE_SEL,
  input wire logic CFG_CLOCK_POLARITY_SEL,
  input wire logic CFG_LSB_FIRST,
  input wire logic CFG_INTERRUPT_SOURCE_SEL,
  input wire logic CFG_FAST_CHANNEL,
  input wire logic [3:0] CFG_PRESCALE,
  input wire logic [6:0] CFG_DIVIDER,
  input wire logic CHANNEL_START,
  input wire logic CHANNEL_STOP_TRIGGER,
  input wire logic DATA_WR,
  input wire logic [7:0] DATA_IN,
  input wire logic OVERFLOW_CLEAR,
  input wire logic RD_DATA_READY,
  input wire logic SI,
  output logic SCK,
  output logic SO,
  output logic CHANNEL_ENABLE_STATUS,
  output logic CHANNEL_STOP_PENDING,
  output logic BUFFER_FULL_FLAG,
  output logic OVERFLOW_FLAG,
  output logic CHAN_IRQ,
  output logic RD_DATA_VALID,
  output logic [7:0] RD_DATA
);
  ssm_state_t q;
  ssm_state_t d;
  logic tick;
  logic load_w;
  logic end_w;
  logic sub_rst;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic fifo_out_ready;
  logic [7:0] fifo_out_data;
  logic [4:0] e;
  logic [4:0] last;
  logic [7:0] rxn;
  logic [7:0] shn;
  logic [7:0] word;

  function automatic ssm_state_t rst_state();
    ssm_state_t s;
    s = '0;
    s.phase = SSM_IDLE;
    s.sck = `SSM_SCK_IDLE_RST;
    s.so = `SSM_SO_IDLE;
    rst_state = s;
  endfunction

  function automatic logic first_bit(input logic [7:0] v,
                                     input logic short_f,
                                     input logic lsb);
    first_bit = lsb ? v[0] : (short_f ? v[6] : v[7]);
  endfunction

  function automatic logic [7:0] shift_out(input logic [7:0] v,
                                           input logic lsb);
    shift_out = lsb ? {1'b0, v[7:1]} : {v[6:0], 1'b0};
  endfunction

  function automatic logic [7:0] shift_in(input logic [7:0] v,
                                          input logic b,
                                          input logic lsb);
    shift_in = lsb ? {b, v[7:1]} : {v[6:0], b};
  endfunction

  // Everything below the unit enable restarts when the unit clock is cut
  assign sub_rst = RESET || !UNIT_CLOCK_ENABLE;
  assign fifo_out_ready = !q.rd_valid || RD_DATA_READY;

  assign SCK = q.sck;
  assign SO = q.so;
  assign CHANNEL_ENABLE_STATUS = q.en;
  assign CHANNEL_STOP_PENDING = q.stop_pend;
  assign BUFFER_FULL_FLAG = q.bfull;
  assign OVERFLOW_FLAG = q.ovf;
  assign CHAN_IRQ = q.irq;
  assign RD_DATA_VALID = q.rd_valid;
  assign RD_DATA = q.rd_data;

  ssm_clkdiv u_div (
    .clk(REF_CLK),
    .rst(sub_rst),
    .run(q.phase == SSM_SHIFT && !q.stop_pend),
    .fast(q.fast),
    .pre(q.pre),
    .div(q.div),
    .tick(tick)
  );

  ssm_fifo #(
    .WIDTH(`SSM_DATA_W),
    .DEPTH(`SSM_FIFO_DEPTH)
  ) u_rx_fifo (
    .clk(REF_CLK),
    .rst(sub_rst),
    .in_valid(q.push),
    .in_ready(fifo_in_ready),
    .in_data(q.push_data),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_out_ready),
    .out_data(fifo_out_data)
  );

  always_comb begin
    d = q;
    load_w = 1'b0;
    end_w = 1'b0;
    d.irq = 1'b0;
    d.push = 1'b0;
    rxn = q.rx;
    shn = q.sh;
    // Edge index: with data phase 1 the first tick is a half-period lead-in
    e = q.t - {4'h0, q.dap};
    last = q.len7 ? `SSM_LAST_EDGE_SHORT : `SSM_LAST_EDGE_LONG; // [R3]
    if (CFG_WR) begin
      d.rx_mode = CFG_RX_MODE;
      d.len7 = CFG_SHORT_FRAME;
      d.dap = CFG_DATA_PHASE_SEL;
      d.ckp = CFG_CLOCK_POLARITY_SEL;
      d.lsb = CFG_LSB_FIRST;
      d.isrc = CFG_INTERRUPT_SOURCE_SEL;
      d.fast = CFG_FAST_CHANNEL;
      d.pre = CFG_PRESCALE;
      d.div = CFG_DIVIDER;
      if (CFG_RX_MODE) begin
        d.so = `SSM_SO_IDLE;
      end
    end
    if (OVERFLOW_CLEAR) begin
      d.ovf = 1'b0;
    end
    if (CHANNEL_START) begin
      d.en = 1'b1;
    end
    if (CHANNEL_STOP_TRIGGER) begin
      d.stop_pend = 1'b1;
    end
    if (DATA_WR) begin
      d.tx_buf = DATA_IN; // [R13]
      d.bfull = 1'b1;
    end
    if (q.stop_pend) begin
      // Abort at once; the trigger drops when the status already reads 0
      d.en = 1'b0;
      d.phase = SSM_IDLE;
      if (!q.en) begin
        d.stop_pend = CHANNEL_STOP_TRIGGER; // [R18]
      end
    end else if (q.phase == SSM_SHIFT && tick) begin
      d.t = q.t + 5'h01;
      if (!(q.dap && q.t == 5'h00)) begin
        d.sck = ~q.sck; // [R1] [R2]
        if (!e[0] == q.dap) begin
          // Phase 1 samples on leading edges, phase 0 on trailing ones
          rxn = shift_in(q.rx, SI, q.lsb); // [R2] [R7] [R9]
          d.rx = rxn;
        end else if (!q.rx_mode) begin
          if (e != 5'h00) begin
            shn = shift_out(q.sh, q.lsb); // [R9]
          end
          d.sh = shn;
          d.so = first_bit(shn, q.len7, q.lsb); // [R1] [R6]
        end
        if (e == last) begin
          end_w = 1'b1;
        end
      end
    end
    word = q.len7 ? (q.lsb ? {1'b0, rxn[7:1]} : {1'b0, rxn[6:0]}) : rxn;
    if (end_w) begin
      d.phase = SSM_IDLE;
      if (!q.isrc) begin
        d.irq = 1'b1; // [R10]
      end
      if (q.rx_mode) begin
        d.push_data = word; // [R20]
        // A full receive path cannot hold this frame: it is lost
        if (fifo_in_ready) begin
          d.push = 1'b1; // [R20]
        end else begin
          d.ovf = 1'b1; // [R12] [R11]
        end
      end
    end
    if (q.en && !q.stop_pend && q.bfull &&
        (q.phase == SSM_IDLE || end_w)) begin
      load_w = 1'b1;
      d.phase = SSM_SHIFT;
      d.t = 5'h00;
      d.sh = q.tx_buf;
      d.rx = 8'h00;
      // A write in the same cycle refills the buffer behind the load
      d.bfull = DATA_WR;
      if (q.isrc) begin
        d.irq = 1'b1; // [R10]
      end
      if (q.dap && !q.rx_mode) begin
        d.so = first_bit(q.tx_buf, q.len7, q.lsb); // [R6]
      end
    end
    if (fifo_out_ready) begin
      d.rd_valid = fifo_out_valid;
      d.rd_data = fifo_out_data;
    end
    if (d.phase == SSM_IDLE) begin
      d.sck = ~d.ckp; // [R19] [R8]
    end
    if (!UNIT_CLOCK_ENABLE) begin
      d = rst_state(); // [R17]
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      q <= rst_state();
    end else begin
      q <= d;
    end
  end

  default clocking cb @(posedge REF_CLK);
  endclocking
  default disable iff (RESET);

  sequence s_load_tx;
    load_w && !q.rx_mode && UNIT_CLOCK_ENABLE;
  endsequence

  sequence s_frame_end;
    end_w && UNIT_CLOCK_ENABLE;
  endsequence

  a_irq_source_sel: assert property (
    q.irq |-> ($past(q.isrc) ? $past(load_w) : $past(end_w))) // [R10]
    else $error("Interrupt pulse without its selected cause");

  a_early_first_bit: assert property (
    s_load_tx ##0 (q.dap && !q.lsb && !q.len7 && !q.stop_pend)
    |=> q.so == $past(q.tx_buf[7])) // [R6]
    else $error("Phase 1 did not present the first bit at load");

  a_late_first_bit: assert property (
    s_load_tx ##0 (!q.dap) |=> $stable(q.so)) // [R6]
    else $error("Phase 0 changed data before the first edge");

  a_overflow_set: assert property (
    s_frame_end ##0 (q.rx_mode && !fifo_in_ready) |=> q.ovf) // [R12]
    else $error("Lost receive frame did not raise overflow");

  a_tx_no_error: assert property (
    $rose(q.ovf) |-> $past(q.rx_mode)) // [R11]
    else $error("Overflow raised in transmit mode");

  a_data_overwrite: assert property (
    DATA_WR && UNIT_CLOCK_ENABLE
    |=> q.bfull && q.tx_buf == $past(DATA_IN)) // [R13]
    else $error("Data write did not replace the pending word");

  a_stop_self_clear: assert property (
    q.stop_pend && !q.en && !CHANNEL_STOP_TRIGGER && UNIT_CLOCK_ENABLE
    |=> !q.stop_pend) // [R18]
    else $error("Stop trigger stayed set with channel stopped");

  a_unit_off_default: assert property (
    !UNIT_CLOCK_ENABLE |=> !q.en && !q.bfull && !q.ovf && !q.irq) // [R17]
    else $error("State kept while unit clock was off");

  a_sck_idle_level: assert property (
    s_frame_end ##0 !load_w |=> (q.sck == ~q.ckp) [*2]) // [R19]
    else $error("Serial clock left idle level after a frame");
endmodule

// ==== ssm_map.svh ====
// Offsets-free constant map of the serial master channel.
// Assumes inclusion by bare name from every file that needs these figures.
`ifndef SSM_MAP_SVH
`define SSM_MAP_SVH
`define SSM_DATA_W 8
`define SSM_FIFO_DEPTH 16
`define SSM_CNT_W 23
`define SSM_HALF_MIN_SLOW 23'h00_0002
`define SSM_LAST_EDGE_SHORT 5'hd
`define SSM_LAST_EDGE_LONG 5'hf
`define SSM_SCK_IDLE_RST 1'b1
`define SSM_SO_IDLE 1'b1
`endif

// ==== ssm_pkg.sv ====
// Types shared by the serial master channel and its clock divider.
// Assumes ssm_map.svh is available on the include path.
package ssm_pkg;
  typedef enum logic {SSM_IDLE, SSM_SHIFT} ssm_phase_t;

  typedef struct packed {
    logic en;
    logic stop_pend;
    logic rx_mode;
    logic len7;
    logic dap;
    logic ckp;
    logic lsb;
    logic isrc;
    logic fast;
    logic [3:0] pre;
    logic [6:0] div;
    logic [7:0] tx_buf;
    logic bfull;
    ssm_phase_t phase;
    logic [4:0] t;
    logic [7:0] sh;
    logic [7:0] rx;
    logic sck;
    logic so;
    logic ovf;
    logic irq;
    logic push;
    logic [7:0] push_data;
    logic rd_valid;
    logic [7:0] rd_data;
  } ssm_state_t;

  typedef struct packed {
    logic [22:0] cnt;
    logic tick;
  } ssm_div_st_t;
endpackage

// ==== ssm_fifo.sv ====
// Synchronous FIFO with valid/ready on both sides, width and depth set
// by parameters. Assumes one clock and a synchronous active-high reset.
`timescale 1ns/10ps
module ssm_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] DEP = (AW+1)'(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW:0] cnt;
    logic [AW-1:0] rp;
    logic [AW-1:0] wp;
  } ssm_fifo_st_t;

  ssm_fifo_st_t q;
  ssm_fifo_st_t d;
  logic push;
  logic pop;

  assign in_ready = (q.cnt != DEP);
  assign out_valid = (q.cnt != '0);
  assign out_data = q.mem[q.rp];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_comb begin
    d = q;
    if (push) begin
      d.mem[q.wp] = in_data;
      d.wp = q.wp + 1'b1;
    end
    if (pop) begin
      d.rp = q.rp + 1'b1;
    end
    if (push && !pop) begin
      d.cnt = q.cnt + 1'b1;
    end else if (pop && !push) begin
      d.cnt = q.cnt - 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end
endmodule

// ==== ssm_clkdiv.sv ====
// Half-period tick generator for the serial clock: prescaler times divider.
// Assumes run stays high for the whole of a frame or burst of frames.
`timescale 1ns/10ps
`include "ssm_map.svh"
module ssm_clkdiv
  import ssm_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic run,
  input wire logic fast,
  input wire logic [3:0] pre,
  input wire logic [6:0] div,
  output logic tick
);
  ssm_div_st_t q;
  ssm_div_st_t d;
  logic [22:0] half;

  assign tick = q.tick;

  always_comb begin
    d = q;
    // Half period is (div+1) * 2^pre cycles, up to 2^22 at the slow end
    half = ({16'h0000, div} + 23'h00_0001) << pre; // [R5]
    // Only the fast channel may toggle every cycle
    if (!fast && half < `SSM_HALF_MIN_SLOW) begin
      half = `SSM_HALF_MIN_SLOW; // [R4]
    end
    if (!run) begin
      d.cnt = '0;
      d.tick = 1'b0;
    end else if (q.cnt >= half - 23'h00_0001) begin
      d.cnt = '0;
      d.tick = 1'b1;
    end else begin
      d.cnt = q.cnt + 23'h00_0001;
      d.tick = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  a_slow_rate_gap: assert property (tick && !fast |=> !tick) // [R4]
    else $error("Slow channel ticked on two adjacent cycles");
endmodule

// ==== ssm_slave_model.sv ====
// Behavioural external slave on the three-wire link of the master.
// Assumes the bench holds en low while it reconfigures the channel.
`timescale 1ns/10ps
module ssm_slave_model
  import ssm_pkg::*;
(
  input wire logic en,
  input wire logic sck,
  input wire logic so,
  input wire logic ckp,
  input wire logic dap,
  input wire logic lsb,
  input wire logic short_f,
  input wire logic [7:0] tx_word,
  output logic si,
  output logic [7:0] rx_word,
  output int frames
);
  int s = 0;
  logic [7:0] sh = 8'h00;
  function automatic logic bitv(input int k);
    int n;
    n = short_f ? 7 : 8;
    return lsb ? tx_word[k] : tx_word[n-1-k];
  endfunction
  initial begin
    rx_word = 8'h00;
    frames = 0;
    si = 1'b1;
  end
  // Preload the first bit so that an early sampling phase finds it
  always @(en, tx_word, lsb, short_f) begin
    if (!en) s = 0;
    if (s == 0) si = bitv(0);
  end
  // Leaving the idle level is the leading edge
  always @(sck) begin
    if (en) begin
      if ((sck == ckp) == dap) begin
        sh = lsb ? {so, sh[7:1]} : {sh[6:0], so};
        s++;
        if (s == (short_f ? 7 : 8)) begin
          rx_word = lsb ? (short_f ? sh >> 1 : sh) : (sh & (short_f ?
            8'h7f : 8'hff));
          frames++;
          s = 0;
          si = bitv(0);
        end
      end else begin
        si = bitv(s);
      end
    end
  end
endmodule

// ==== simple_spi_master_txrx_test.sv ====
// Self-checking bench for the serial master channel with a slave model.
// Assumes the design's REF_CLK at 200 MHz and synchronous RESET.
`timescale 1ns/10ps
module simple_spi_master_txrx_test;
  logic clk = 0, rst = 1, uce = 1, cfg_wr = 0, start = 0, stop = 0;
  logic dwr = 0, ovc = 0, rdy = 0, live = 0;
  logic [6:0] m = 0, dv = 0;
  logic [3:0] pre = 0;
  logic [7:0] din = 0, stx = 0, d;
  logic sck, so, si, ces, csp, bff, ovf, irq, rv;
  logic [7:0] rd, srx;
  int frm, fail_count = 0, tests_run = 0, irqs = 0, cyc = 0, i, f0, n0;
  real lt = 0, hmin = 1e9;
  ssm_master i_ssm_master (.REF_CLK(clk), .RESET(rst),
    .UNIT_CLOCK_ENABLE(uce), .CFG_WR(cfg_wr), .CFG_RX_MODE(m[6]),
    .CFG_SHORT_FRAME(m[5]), .CFG_DATA_PHASE_SEL(m[4]),
    .CFG_CLOCK_POLARITY_SEL(m[3]), .CFG_LSB_FIRST(m[2]),
    .CFG_INTERRUPT_SOURCE_SEL(m[1]), .CFG_FAST_CHANNEL(m[0]),
    .CFG_PRESCALE(pre), .CFG_DIVIDER(dv), .CHANNEL_START(start),
    .CHANNEL_STOP_TRIGGER(stop), .DATA_WR(dwr), .DATA_IN(din),
    .OVERFLOW_CLEAR(ovc), .RD_DATA_READY(rdy), .SI(si), .SCK(sck),
    .SO(so), .CHANNEL_ENABLE_STATUS(ces), .CHANNEL_STOP_PENDING(csp),
    .BUFFER_FULL_FLAG(bff), .OVERFLOW_FLAG(ovf), .CHAN_IRQ(irq),
    .RD_DATA_VALID(rv), .RD_DATA(rd));
  ssm_slave_model i_ssm_slave_model (.en(live), .sck(sck), .so(so),
    .ckp(m[3]), .dap(m[4]), .lsb(m[2]), .short_f(m[5]), .tx_word(stx),
    .si(si), .rx_word(srx), .frames(frm));
  always #2.5 clk = ~clk;
  // Shortest serial half period seen, in nanoseconds
  always @(sck) begin
    if ($realtime - lt < hmin) hmin = $realtime - lt;
    lt = $realtime;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (irq === 1'b1) irqs <= irqs + 1;
    if (cyc == 20000) begin
      fail_count++;
      report_and_stop();
    end
  end
  task report_and_stop();
    $display("counts: tests_run=%0d fail_count=%0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task chk_w(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task chk_b(input logic got, input logic exp);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task tick(input int n);
    repeat (n) @(negedge clk);
  endtask
  // Slave is parked while the idle clock level may flip
  task setup(input logic [6:0] mm, input logic [3:0] p, input logic [6:0] k);
    live = 0;
    m = mm;
    pre = p;
    dv = k;
    cfg_wr = 1;
    tick(1);
    cfg_wr = 0;
    start = 1;
    tick(1);
    start = 0;
    tick(2);
    live = 1;
    hmin = 1e9;
  endtask
  task put(input logic [7:0] w);
    din = w;
    dwr = 1;
    tick(1);
    dwr = 0;
    tick(1);
  endtask
  task wait_frm(input int f);
    int k;
    for (k = 0; k < 3000 && frm == f; k++) tick(1);
    chk_w(8'(frm - f), 8'h01);
  endtask
  function automatic logic [7:0] msk(input logic [7:0] w, input logic s);
    return s ? (w & 8'h7f) : w;
  endfunction
  initial begin
    tick(6);
    rst = 0;
    tick(2);
    for (i = 0; i < 16; i++) begin
      setup({1'b0, i[3], i[2], i[1], i[0], i[3], i[2]}, 4'h0, 7'h00);
      f0 = frm;
      n0 = irqs;
      d = 8'ha5 ^ 8'(i * 29);
      put(d);
      tick(2);
      chk_w(8'(irqs - n0), 8'(i[3]));
      wait_frm(f0);
      tick(4);
      chk_w(srx, msk(d, i[3]));
      chk_w(8'(irqs - n0), 8'h01);
      chk_b(sck, ~i[1]);
      chk_w(8'(int'(hmin / 5.0)), i[2] ? 8'h01 : 8'h02);
      chk_b(ovf, 1'b0);
    end
    $display("test transmit done");
    for (i = 0; i < 16; i++) begin
      stx = 8'h3c ^ 8'(i * 41);
      setup({1'b1, i[3], i[2], i[1], i[0], 2'b01}, 4'h0, 7'h00);
      f0 = frm;
      put(8'hff);
      wait_frm(f0);
      for (n0 = 0; n0 < 50 && rv !== 1'b1; n0++) tick(1);
      chk_w(rd, msk(stx, i[3]));
      rdy = 1;
      tick(1);
      rdy = 0;
      tick(1);
    end
    $display("test receive done");
    setup(7'b0000010, 4'h2, 7'h02);
    f0 = frm;
    put(8'h11);
    tick(3);
    put(8'h22);
    chk_b(bff, 1'b1);
    put(8'h33);
    wait_frm(f0);
    chk_w(srx, 8'h11);
    chk_w(8'(int'(hmin / 5.0)), 8'h0c);
    wait_frm(f0 + 1);
    chk_w(srx, 8'h33);
    tick(300);
    chk_w(8'(frm - f0), 8'h02);
    $display("test overwrite done");
    setup(7'b1000001, 4'h0, 7'h00);
    for (i = 0; i < 18; i++) begin
      if (i == 17) chk_b(ovf, 1'b0);
      f0 = frm;
      put(8'h00);
      wait_frm(f0);
      tick(6);
    end
    chk_b(ovf, 1'b1);
    ovc = 1;
    tick(1);
    ovc = 0;
    tick(1);
    chk_b(ovf, 1'b0);
    rdy = 1;
    tick(30);
    rdy = 0;
    chk_b(rv, 1'b0);
    $display("test overflow done");
    // Source select moves from continuous to single while a frame shifts
    for (i = 0; i < 2; i++) begin
      setup({i[0], 6'b000010}, 4'h0, 7'h02);
      f0 = frm;
      n0 = irqs;
      put(8'h96);
      tick(6);
      m[1] = 1'b0;
      cfg_wr = 1;
      tick(1);
      cfg_wr = 0;
      wait_frm(f0);
      tick(6);
      chk_w(8'(irqs - n0), 8'h02);
    end
    $display("test source switch done");
    setup(7'b0000000, 4'h2, 7'h02);
    f0 = frm;
    n0 = irqs;
    put(8'h5a);
    tick(40);
    chk_b(ces, 1'b1);
    stop = 1;
    tick(1);
    stop = 0;
    chk_b(csp, 1'b1);
    chk_b(ces, 1'b1);
    tick(3);
    chk_b(ces, 1'b0);
    chk_b(csp, 1'b0);
    tick(300);
    chk_w(8'(frm - f0), 8'h00);
    chk_w(8'(irqs - n0), 8'h00);
    chk_b(sck, 1'b1);
    $display("test stop done");
    uce = 0;
    tick(1);
    start = 1;
    tick(1);
    start = 0;
    put(8'h77);
    chk_b(ces, 1'b0);
    chk_b(bff, 1'b0);
    uce = 1;
    tick(2);
    chk_b(ces, 1'b0);
    // Clock was cut after a stop: set the channel up again, never resume
    setup(7'b0000000, 4'h0, 7'h00);
    f0 = frm;
    put(8'hc3);
    wait_frm(f0);
    chk_w(srx, 8'hc3);
    $display("test unit clock off done");
    report_and_stop();
  end
endmodule
